//--- hw/eeprom_device.sv
// Slave-side command logic of the two-wire serial EEPROM.
//
// Chosen here: the register offsets and the AHB-Lite slave port.

// Notes on behaviour
// - Address byte: type 1010, chip selects, direction.
// - Write sends two word address bytes, high first.
// - Master sends top three high-address bits zero.
// - Acknowledge address and data bytes in ninth clock.
// - Program cycle begins at the stop condition.
// - Ignore the bus while programming.
// - Program cycle ends within ten milliseconds.
// - Page write takes up to thirty-two acknowledged bytes.
// - Address advances per byte and wraps, overwriting.
// - Polling gets no acknowledge until programming ends.
// - Protected upper half: refuse data, no program.
// - Low supply during write refuses it, no acknowledge.
// - Read starts like write with direction bit one.
// - Counter holds last accessed location plus one.
// - Read address acknowledged, then eight data bits.
// - Random read: dummy write, repeated start, read.
// - Keep sending while master acknowledges each byte.
// - On no acknowledge, release and await stop.
// - Read counter walks whole array and wraps.
module eeprom_device #(
  parameter int PROG_CYCLES = eeprom_pkg::T_WR_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  eeprom_link_if.device link,
  input wire logic [2:0] chip_select_pins,
  input wire logic write_protect,
  input wire logic low_supply,
  output logic program_busy
);
  localparam int TMR_W = $clog2(PROG_CYCLES + 1);

  logic [6:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic lows_s;
  logic [2:0] cs_s;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  eeprom_pkg::dev_state_e state;
  logic [3:0] bitcnt;
  logic [7:0] rx;
  logic [7:0] tx;
  logic [eeprom_pkg::ADDR_W-1:0] addr;
  logic [4:0] addr_hi;
  logic sda_drive;
  logic busy;
  logic [TMR_W-1:0] tmr;
  logic commit;
  logic pending;
  logic lowv_seen;
  logic [eeprom_pkg::PAGE_BYTES-1:0] bvalid;
  logic [7:0] page_buf [eeprom_pkg::PAGE_BYTES];
  logic [7:0] mem [eeprom_pkg::MEM_DEPTH];
  logic [7:0] rd_byte;
  logic byte_end;
  logic ctrl_ok;
  logic data_ok;
  logic wr_accept;
  logic wr_refuse;
  logic prog_start;

  // Next address inside the current page: upper bits hold, low bits wrap.
  function automatic logic [eeprom_pkg::ADDR_W-1:0] page_next(input logic [eeprom_pkg::ADDR_W-1:0] a);
    page_next = {a[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_W], a[eeprom_pkg::PAGE_W-1:0] + 5'h1};
  endfunction

  // The link pins, the write-protect level, the supply flag and the straps all cross in here.
  sync2 #(.W(7)) pin_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({link.scl, link.sda, write_protect, low_supply, chip_select_pins}),
    .sync_out(pins_s)
  );

  assign {scl_s, sda_s, wp_s, lows_s, cs_s} = pins_s;

  // Previous synchronised levels for edge and condition detection.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_d <= 1'b0;
      sda_d <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Clock edges and start/stop conditions, a data change while the clock stays high.
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_seen = scl_s & scl_d & ~sda_d & sda_s;

  // Byte decisions taken on the falling edge that closes the eighth bit.
  assign byte_end = scl_fall && (bitcnt == 4'h8) && (state != eeprom_pkg::DS_IDLE) && (state != eeprom_pkg::DS_RDATA);
  assign ctrl_ok = (rx[7:4] == eeprom_pkg::DEV_TYPE) && (rx[3:1] == cs_s);
  assign data_ok = !(wp_s && addr[eeprom_pkg::PROT_BIT]) && !lowv_seen && !lows_s;
  assign wr_accept = byte_end && (state == eeprom_pkg::DS_WDATA) && data_ok;
  assign wr_refuse = byte_end && (state == eeprom_pkg::DS_WDATA) && !data_ok;
  assign prog_start = stop_seen && !busy && pending && !lowv_seen && !lows_s;
  assign commit = busy && (tmr == '0);
  assign rd_byte = mem[addr[eeprom_pkg::MEM_AW-1:0]];

  // Serial protocol: bit counting, acknowledge, address counter and read shifting.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= eeprom_pkg::DS_IDLE;
      bitcnt <= 4'h0;
      rx <= 8'h00;
      tx <= 8'h00;
      addr <= '0;
      addr_hi <= 5'h00;
      sda_drive <= 1'b0;
    end else if (busy) begin
      state <= eeprom_pkg::DS_IDLE;
      sda_drive <= 1'b0;
    end else if (start_seen) begin
      state <= eeprom_pkg::DS_CTRL;
      bitcnt <= 4'h0;
      sda_drive <= 1'b0;
    end else if (stop_seen) begin
      state <= eeprom_pkg::DS_IDLE;
      sda_drive <= 1'b0;
    end else if (state != eeprom_pkg::DS_IDLE) begin
      if (scl_rise) begin
        if (bitcnt == 4'h8) begin
          bitcnt <= 4'h0;
          // A high level in the master's acknowledge slot ends the read.
          if (state == eeprom_pkg::DS_RDATA && sda_s) begin
            state <= eeprom_pkg::DS_IDLE;
          end
        end else begin
          rx <= {rx[6:0], sda_s};
          bitcnt <= bitcnt + 4'h1;
        end
      end else if (scl_fall) begin
        if (state == eeprom_pkg::DS_RDATA) begin
          if (bitcnt == 4'h0) begin
            tx <= {rd_byte[6:0], 1'b0};
            sda_drive <= ~rd_byte[7];
            addr <= addr + 13'h0001;
          end else if (bitcnt == 4'h8) begin
            sda_drive <= 1'b0;
          end else begin
            sda_drive <= ~tx[7];
            tx <= {tx[6:0], 1'b0};
          end
        end else if (bitcnt == 4'h0) begin
          sda_drive <= 1'b0;
        end else if (bitcnt == 4'h8) begin
          unique case (state)
            eeprom_pkg::DS_CTRL: begin
              if (ctrl_ok) begin
                sda_drive <= 1'b1;
                state <= rx[0] ? eeprom_pkg::DS_RDATA : eeprom_pkg::DS_ADDR_H;
              end else begin
                state <= eeprom_pkg::DS_IDLE;
              end
            end
            eeprom_pkg::DS_ADDR_H: begin
              sda_drive <= 1'b1;
              addr_hi <= rx[4:0];
              state <= eeprom_pkg::DS_ADDR_L;
            end
            eeprom_pkg::DS_ADDR_L: begin
              sda_drive <= 1'b1;
              addr <= {addr_hi, rx};
              state <= eeprom_pkg::DS_WDATA;
            end
            eeprom_pkg::DS_WDATA: begin
              if (data_ok) begin
                sda_drive <= 1'b1;
                addr <= page_next(addr);
              end else begin
                state <= eeprom_pkg::DS_IDLE;
              end
            end
            default: begin
              state <= eeprom_pkg::DS_IDLE;
            end
          endcase
        end
      end
    end
  end

  // Page buffer: a new byte at an already filled slot overwrites it.
  always_ff @(posedge hclk) begin
    if (wr_accept) begin
      page_buf[addr[eeprom_pkg::PAGE_W-1:0]] <= rx;
    end
  end

  // Pending write: a start or a refused byte drops it, the end of programming retires it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pending <= 1'b0;
      bvalid <= '0;
    end else if (commit || (start_seen && !busy) || wr_refuse) begin
      pending <= 1'b0;
      bvalid <= '0;
    end else if (wr_accept) begin
      pending <= 1'b1;
      bvalid[addr[eeprom_pkg::PAGE_W-1:0]] <= 1'b1;
    end
  end

  // Low-supply watch from the first address byte of a write until the next start or the end of its program cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lowv_seen <= 1'b0;
    end else if (start_seen && !busy) begin
      lowv_seen <= 1'b0;
    end else if (lows_s && (pending || state == eeprom_pkg::DS_ADDR_H || state == eeprom_pkg::DS_ADDR_L
                            || state == eeprom_pkg::DS_WDATA)) begin
      lowv_seen <= 1'b1;
    end
  end

  // Program cycle timer, started by the stop that closes an accepted write.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 1'b0;
      tmr <= '0;
    end else if (prog_start) begin
      busy <= 1'b1;
      tmr <= TMR_W'(PROG_CYCLES - 1);
    end else if (commit) begin
      busy <= 1'b0;
    end else if (busy) begin
      tmr <= tmr - TMR_W'(1);
    end
  end

  // Array update at the end of the program cycle; the array itself is not reset.
  always_ff @(posedge hclk) begin
    if (commit) begin
      for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin
        if (bvalid[i]) begin
          mem[{addr[eeprom_pkg::MEM_AW-1:eeprom_pkg::PAGE_W], eeprom_pkg::PAGE_W'(i)}] <= page_buf[i];
        end
      end
    end
  end

  // Open-drain data: the driver only ever pulls low.
  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe = sda_drive;
  assign program_busy = busy;
endmodule

//--- hw/eeprom_pkg.sv
// Shared constants and types for the two-wire EEPROM link and its bus-side controller.
package eeprom_pkg;

  // Device type nibble expected in the top of the slave address byte.
  localparam logic [3:0] DEV_TYPE = 4'ha;

  // Array geometry: 13-bit word address, 4K bytes of storage, 32-byte pages.
  localparam int ADDR_W = 13;
  localparam int MEM_DEPTH = 4096;
  localparam int MEM_AW = 12;
  localparam int PAGE_W = 5;
  localparam int PAGE_BYTES = 32;
  localparam int PROT_BIT = 11;

  // Program cycle time and its length in system clock cycles (longest time, rounded down).
  localparam int CLK_KHZ = 40000;
  localparam int T_WR_MS = 10;
  localparam int T_WR_CYCLES = T_WR_MS * CLK_KHZ;

  // Controller register byte offsets.
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DIV = 8'h08;

  // Command register fields; data byte sits in bits 7..0.
  localparam int CMD_W = 13;
  localparam int CMD_START = 8;
  localparam int CMD_STOP = 9;
  localparam int CMD_READ = 10;
  localparam int CMD_NACK = 11;
  localparam int CMD_NOBYTE = 12;

  // Quarter-bit divider width and value after reset.
  localparam int DIV_W = 16;
  localparam logic [15:0] DIV_RESET = 16'h000a;

  // Device protocol states.
  typedef enum logic [2:0] {
    DS_IDLE = 3'b000,
    DS_CTRL = 3'b001,
    DS_ADDR_H = 3'b010,
    DS_ADDR_L = 3'b011,
    DS_WDATA = 3'b100,
    DS_RDATA = 3'b101
  } dev_state_e;

  // Controller sequencer states.
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_START = 2'b01,
    HS_BIT = 2'b10,
    HS_STOP = 2'b11
  } host_state_e;

endpackage

//--- hw/eeprom_link_if.sv
// Two-wire link between the controller and the EEPROM, with the open-drain data wire resolved.
interface eeprom_link_if;
  logic scl;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic sda;

  // The pull-up holds the wire high unless an enabled driver pulls it.
  assign sda = (host_sda_oe ? host_sda_out : 1'b1) & (dev_sda_oe ? dev_sda_out : 1'b1);

  modport host (output scl, output host_sda_out, output host_sda_oe, input sda);
  modport device (input scl, output dev_sda_out, output dev_sda_oe, input sda);
endinterface

//--- hw/sync2.sv
// Two-flip-flop synchroniser for inputs from outside the system clock domain.
module sync2 #(
  parameter int W = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta;

  // The first stage is read only by the second stage.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

//--- hw/eeprom_host.sv
// Two-wire bus controller for the EEPROM, commanded over an AHB-Lite register slave.
module eeprom_host (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  eeprom_link_if.host link
);
  logic addr_phase;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [eeprom_pkg::DIV_W-1:0] div;
  logic [eeprom_pkg::DIV_W-1:0] divcnt;
  logic launch;
  logic [eeprom_pkg::CMD_W-1:0] cmd;
  eeprom_pkg::host_state_e hs;
  logic [1:0] q;
  logic [3:0] bitn;
  logic [7:0] shreg;
  logic ack_got;
  logic scl_q;
  logic sda_drv;
  logic sda_s;
  logic busy;

  // Returned data line, sampled through two flip-flops.
  sync2 #(.W(1)) sda_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(link.sda),
    .sync_out(sda_s)
  );

  // A transfer is taken only for a selected, active, ready address phase; hsize is always a word.
  assign addr_phase = hsel && hready && htrans[1];
  assign busy = (hs != eeprom_pkg::HS_IDLE);
  assign launch = wr_pend && (wr_addr == eeprom_pkg::REG_CMD) && !busy;

  // Bus slave: zero wait states, OKAY always, read data captured at the address phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= addr_phase && hwrite;
      wr_addr <= haddr[7:0];
      if (addr_phase && !hwrite) begin
        case (haddr[7:0])
          eeprom_pkg::REG_CMD: hrdata <= 32'(cmd);
          eeprom_pkg::REG_STATUS: hrdata <= {16'h0000, shreg, 6'h00, ack_got, busy};
          eeprom_pkg::REG_DIV: hrdata <= 32'(div);
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Quarter-bit divider setting.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div <= eeprom_pkg::DIV_RESET;
    end else if (wr_pend && wr_addr == eeprom_pkg::REG_DIV) begin
      div <= hwdata[eeprom_pkg::DIV_W-1:0];
    end
  end

  // Sequencer: each bit is four quarters, data bits change only with the clock low; start and stop move data with the clock high.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs <= eeprom_pkg::HS_IDLE;
      cmd <= '0;
      q <= 2'h0;
      bitn <= 4'h0;
      shreg <= 8'h00;
      ack_got <= 1'b0;
      divcnt <= '0;
      scl_q <= 1'b1;
      sda_drv <= 1'b0;
    end else if (hs == eeprom_pkg::HS_IDLE) begin
      divcnt <= '0;
      q <= 2'h0;
      if (launch) begin
        cmd <= hwdata[eeprom_pkg::CMD_W-1:0];
        shreg <= hwdata[7:0];
        bitn <= 4'h0;
        if (hwdata[eeprom_pkg::CMD_START]) begin
          hs <= eeprom_pkg::HS_START;
        end else if (hwdata[eeprom_pkg::CMD_NOBYTE]) begin
          hs <= eeprom_pkg::HS_STOP;
        end else begin
          hs <= eeprom_pkg::HS_BIT;
        end
      end
    end else if (divcnt != div - 16'h0001) begin
      divcnt <= divcnt + 16'h0001;
    end else begin
      divcnt <= '0;
      q <= q + 2'h1;
      unique case (hs)
        eeprom_pkg::HS_START: begin
          // Release, raise the clock, pull data low under it: also a repeated start.
          case (q)
            2'h0: sda_drv <= 1'b0;
            2'h1: scl_q <= 1'b1;
            2'h2: sda_drv <= 1'b1;
            default: begin
              scl_q <= 1'b0;
              hs <= cmd[eeprom_pkg::CMD_NOBYTE] ? eeprom_pkg::HS_STOP : eeprom_pkg::HS_BIT;
            end
          endcase
        end
        eeprom_pkg::HS_BIT: begin
          case (q)
            2'h0: begin
              if (bitn == 4'h8) begin
                sda_drv <= cmd[eeprom_pkg::CMD_READ] && !cmd[eeprom_pkg::CMD_NACK];
              end else begin
                sda_drv <= !cmd[eeprom_pkg::CMD_READ] && !shreg[7];
              end
            end
            2'h1: scl_q <= 1'b1;
            2'h2: begin
              if (bitn == 4'h8) begin
                ack_got <= !sda_s;
              end else begin
                shreg <= {shreg[6:0], sda_s};
              end
            end
            default: begin
              scl_q <= 1'b0;
              bitn <= bitn + 4'h1;
              if (bitn == 4'h8) begin
                hs <= cmd[eeprom_pkg::CMD_STOP] ? eeprom_pkg::HS_STOP : eeprom_pkg::HS_IDLE;
              end
            end
          endcase
        end
        eeprom_pkg::HS_STOP: begin
          // Data low under a low clock, raise the clock, then release data.
          case (q)
            2'h0: sda_drv <= 1'b1;
            2'h1: scl_q <= 1'b1;
            2'h2: sda_drv <= 1'b0;
            default: hs <= eeprom_pkg::HS_IDLE;
          endcase
        end
      endcase
    end
  end

  // The controller makes the clock; data is open drain.
  assign link.scl = scl_q;
  assign link.host_sda_out = 1'b0;
  assign link.host_sda_oe = sda_drv;
endmodule

//--- tb/eeprom_link_checker.sv
// Concurrent checks on the two-wire link between the controller and the EEPROM device.
module eeprom_link_checker #(
  parameter int PROG_CYCLES = 200
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe,
  input wire logic [2:0] chip_select_pins,
  input wire logic program_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_q;
  logic sda_q;
  logic [3:0] bcnt;
  logic [7:0] byt;
  logic [7:0] sh;
  logic [7:0] ctl;
  logic quiet;
  logic nk;
  logic wd;
  int bcyc;
  logic start;
  logic stop;
  logic ackr;
  logic ok;

  // Frame events seen on the wire, and whether the control byte names this device.
  assign start = scl & scl_q & sda_q & ~sda;
  assign stop = scl & scl_q & ~sda_q & sda;
  assign ackr = scl & ~scl_q & (bcnt == 4'h8);
  assign ok = ctl[7:1] == {eeprom_pkg::DEV_TYPE, chip_select_pins};

  // Previous line levels and the length of the current program cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bcyc <= 0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      bcyc <= program_busy ? bcyc + 1 : 0;
    end
  end

  // Bit and byte position inside a frame; the first byte is kept as the control byte.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bcnt <= 4'h0;
      byt <= 8'h00;
      sh <= 8'h00;
      ctl <= 8'h00;
    end else if (start) begin
      bcnt <= 4'h0;
      byt <= 8'h00;
    end else if (scl && !scl_q) begin
      bcnt <= (bcnt == 4'h8) ? 4'h0 : bcnt + 4'h1;
      sh <= {sh[6:0], sda};
      if (bcnt == 4'h8 && byt != 8'hff) byt <= byt + 8'h01;
      if (bcnt == 4'h7 && byt == 8'h00) ctl <= {sh[6:0], sda};
    end
  end

  // Frame flags: busy seen, master refused a read byte, a write data byte was taken.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      quiet <= 1'b0;
      nk <= 1'b0;
      wd <= 1'b0;
    end else if (start || stop) begin
      quiet <= program_busy;
      nk <= 1'b0;
      wd <= 1'b0;
    end else begin
      if (program_busy) quiet <= 1'b1;
      if (ackr && byt != 8'h00 && ctl[0] && sda) nk <= 1'b1;
      if (ackr && byt > 8'h02 && !ctl[0] && ok && !sda) wd <= 1'b1;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  oe_low_clock_a: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device drive changed while clock high");
  busy_mute_a: assert property (program_busy |-> !dev_sda_oe)
    else $error("device drives the line while programming");
  poll_nack_a: assert property (ackr && byt == 8'h00 && program_busy |-> sda)
    else $error("address acknowledged during program cycle");
  ctrl_ack_a: assert property (ackr && byt == 8'h00 && ok && !quiet |-> !sda)
    else $error("matching address not acknowledged");
  ctrl_nack_a: assert property (ackr && byt == 8'h00 && !ok |-> sda)
    else $error("foreign address acknowledged");
  addr_ack_a: assert property (ackr && byt inside {8'h01, 8'h02} && !ctl[0] && ok && !quiet |-> !sda)
    else $error("word address byte not acknowledged");
  rd_release_a: assert property (ackr && byt != 8'h00 && ctl[0] && ok && !quiet |-> !dev_sda_oe)
    else $error("device holds the line in the master acknowledge slot");
  nack_quiet_a: assert property (nk |-> !dev_sda_oe)
    else $error("device drives after a refused read byte");
  prog_start_a: assert property (stop && wd |-> ##[1:8] program_busy)
    else $error("program cycle did not start at stop");
  prog_len_a: assert property ($fell(program_busy) |-> bcyc <= PROG_CYCLES && bcyc >= PROG_CYCLES - 2)
    else $error("program cycle length wrong");

  wr_prog_c: cover property (stop && wd);
  poll_busy_c: cover property (ackr && byt == 8'h00 && program_busy);
  rd_nack_c: cover property (nk && stop);
endmodule

//--- tb/testbench.sv
// Self-checking bench: AHB-Lite orders to the controller, which works the EEPROM device over the link.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PROG = 2000;
  localparam logic [2:0] CS = 3'b101;
  localparam logic [31:0] ST = 32'h0000_0001 << eeprom_pkg::CMD_START;
  localparam logic [31:0] SP = 32'h0000_0001 << eeprom_pkg::CMD_STOP;
  localparam logic [31:0] RD = 32'h0000_0001 << eeprom_pkg::CMD_READ;
  localparam logic [31:0] NK = 32'h0000_0001 << eeprom_pkg::CMD_NACK;
  localparam logic [31:0] ACK = 32'h0000_0002;
  localparam logic [31:0] NONE = 32'h0000_0000;
  localparam logic [31:0] BYTE = 32'h0000_ff00;
  localparam logic [7:0] CW = {eeprom_pkg::DEV_TYPE, CS, 1'b0};
  typedef struct packed {logic [31:0] e; logic [31:0] m;} note_s;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic wp = 1'b0;
  logic ls = 1'b0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic busy;
  logic dph = 1'b0;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  note_s q[$];
  note_s n;
  logic [7:0] mdl [0:4095];

  eeprom_link_if link ();
  eeprom_host eeprom_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .link(link.host));
  eeprom_device #(.PROG_CYCLES(PROG)) eeprom_device_inst (.hclk(hclk), .hresetn(hresetn), .link(link.device),
    .chip_select_pins(CS), .write_protect(wp), .low_supply(ls), .program_busy(busy));
  eeprom_link_checker #(.PROG_CYCLES(PROG)) eeprom_link_checker_inst (.hclk(hclk), .hresetn(hresetn),
    .scl(link.scl), .sda(link.sda), .dev_sda_oe(link.dev_sda_oe), .chip_select_pins(CS), .program_busy(busy));

  // The 40 MHz system clock.
  always #12.5 hclk = ~hclk;

  // Prints the verdict and ends the run.
  task automatic finish_test();
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Compares one value and reports a difference.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Cuts a hung run short.
  always @(posedge hclk) begin
    cycles++;
    if (cycles >= 95000) begin
      miscompares++;
      finish_test();
    end
  end

  // Read data phases: the oldest note is matched against the returned word.
  always @(posedge hclk) begin
    if (dph && hreadyout === 1'b1 && q.size() > 0) begin
      n = q.pop_front();
      check("hresp", 32'(hresp), NONE);
      if (n.m != 32'h0000_0000) check("hrdata", hrdata & n.m, n.e);
    end
    if (hreadyout === 1'b1) dph = (htrans == 2'b10) && !hwrite;
  end

  // One single transfer; returns just after the edge that closes its data phase.
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // Register read whose expected value, under a mask, is noted for the monitor.
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, output logic [31:0] r);
    q.push_back('{e & m, m});
    ahb(1'b0, a, 32'h0000_0000, r);
  endtask

  // Waits until the controller reports no transfer in flight.
  task automatic idle();
    logic [31:0] r;
    do rd(eeprom_pkg::REG_STATUS, NONE, NONE, r); while (r[0] !== 1'b0);
  endtask

  // Sends one command, lets it finish, then notes the expected status.
  task automatic xf(input logic [31:0] c, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] r;
    idle();
    ahb(1'b1, eeprom_pkg::REG_CMD, c, r);
    idle();
    rd(eeprom_pkg::REG_STATUS, e, m, r);
  endtask

  // Start, write control byte and both word address bytes.
  task automatic whdr(input logic [12:0] a);
    xf(ST | CW, ACK, ACK);
    xf({3'b000, a[12:8]}, ACK, ACK);
    xf(a[7:0], ACK, ACK);
  endtask

  // Acknowledge polling across one program cycle.
  task automatic settle();
    int k;
    xf(ST | SP | CW, NONE, ACK);
    k = 0;
    while (busy === 1'b1 && k < 5000) begin
      @(posedge hclk);
      k++;
    end
    xf(ST | SP | CW, ACK, ACK);
  endtask

  // Main sequence.
  initial begin
    logic [31:0] r;
    logic [31:0] v;
    logic [7:0] d;
    int k;
    r = $urandom(32'hf521);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(eeprom_pkg::REG_STATUS, NONE, 32'hffff_ffff, r);
    rd(eeprom_pkg::REG_DIV, {16'h0000, eeprom_pkg::DIV_RESET}, 32'hffff_ffff, r);
    rd(8'h0c, NONE, 32'hffff_ffff, r);
    v = 32'h0000_0008 + ($urandom % 4);
    ahb(1'b1, eeprom_pkg::REG_DIV, v, r);
    rd(eeprom_pkg::REG_DIV, v, 32'hffff_ffff, r);
    // Page write of 34 bytes, two more than a page holds, overwriting its first two bytes.
    whdr(13'h0ffe);
    for (k = 0; k < 34; k++) begin
      d = 8'($urandom);
      mdl[{7'h7f, 5'(30 + k)}] = d;
      xf((k == 33) ? (SP | d) : d, ACK, ACK);
    end
    settle();
    // Current-address read lands on the wrapped page counter.
    xf(ST | CW | 32'h0000_0001, ACK, ACK);
    xf(RD | NK | SP, {mdl[12'hfe0], 8'h00}, BYTE);
    // Protected upper half, then low supply: data refused and nothing programmed.
    for (k = 0; k < 2; k++) begin
      wp <= (k == 0);
      ls <= (k == 1);
      whdr(13'h0800);
      xf(SP | 32'h0000_005a, NONE, ACK);
      xf(ST | SP | CW, ACK, ACK);
    end
    // Lower half still writable with protection on.
    wp <= 1'b1;
    ls <= 1'b0;
    d = 8'($urandom);
    mdl[0] = d;
    whdr(13'h0000);
    xf(SP | d, ACK, ACK);
    settle();
    wp <= 1'b0;
    // Wrong device type and wrong chip select are both ignored.
    xf(ST | SP | {4'h5, CS, 1'b0}, NONE, ACK);
    xf(ST | SP | {eeprom_pkg::DEV_TYPE, ~CS, 1'b0}, NONE, ACK);
    // Random read that runs off the top of the array back to location zero.
    whdr(13'h1fe0);
    xf(ST | CW | 32'h0000_0001, ACK, ACK);
    for (k = 0; k < 33; k++) begin
      xf(RD | ((k == 32) ? (NK | SP) : NONE), {mdl[12'(12'hfe0 + k)], 8'h00}, BYTE);
    end
    repeat (2) @(posedge hclk);
    finish_test();
  end
endmodule
